// ### scrp_pkg.sv
package scrp_pkg;
   // Command opcodes carried by the first byte of each transfer.
   localparam logic [7:0] SCRP_OP_READ = 8'h03;
   localparam logic [7:0] SCRP_OP_WRITE = 8'h02;
   // Strap code that selects the serial client port.
   localparam logic [1:0] SCRP_STRAP_SPI = 2'h2;
   // Clock edges after reset release before the strap is latched.
   localparam logic [1:0] SCRP_STRAP_SETTLE = 2'h2;
   // Number of implemented configuration registers and their reset value.
   localparam int SCRP_NUM_REGS = 198;
   localparam logic [7:0] SCRP_REG_RESET = 8'h00;
   // Window of registers that front the indirectly reached tables.
   localparam logic [7:0] SCRP_IND_FIRST = 8'h79;
   localparam logic [7:0] SCRP_IND_LAST = 8'h83;
   // Value of the output pin when no read byte is being shifted.
   localparam logic SCRP_SDO_IDLE = 1'b0;
   // Bit counter value of the last bit of a byte.
   localparam logic [2:0] SCRP_LAST_BIT = 3'h7;

   typedef enum logic [4:0] {
      SCRP_ST_IDLE = 5'b00001,
      SCRP_ST_CMD = 5'b00010,
      SCRP_ST_ADDR = 5'b00100,
      SCRP_ST_DATA = 5'b01000,
      SCRP_ST_SKIP = 5'b10000
   } scrp_state_t;
endpackage : scrp_pkg

// ### scrp_regfile.sv
`timescale 1ns/100ps
module scrp_regfile #(
   parameter int DEPTH = 198,
   parameter int AW = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Write port.
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Serial-side read port, registered.
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   // Switch-core read port, registered.
   input wire logic [AW-1:0] core_addr,
   output logic [7:0] core_data
);
   import scrp_pkg::*;

   logic [7:0] mem_q [DEPTH];

   initial begin
      if (DEPTH < 1 || DEPTH > (1 << AW)) begin
         $error("scrp_regfile: DEPTH does not fit the address width");
      end
   end

   // Storage; out-of-range writes are dropped so stray addresses cannot alias.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= SCRP_REG_RESET;
         end
      end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Registered reads; unimplemented addresses read as zero.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 8'h00;
         core_data <= 8'h00;
      end else begin
         rd_data <= (int'(rd_addr) < DEPTH) ? mem_q[rd_addr] : 8'h00;
         core_data <= (int'(core_addr) < DEPTH) ? mem_q[core_addr] : 8'h00;
      end
   end
endmodule : scrp_regfile

// ### scrp_spi_client.sv
`timescale 1ns/100ps
// Functional notes
// - Opcode 0x03 starts a register read, 0x02 a register write; others ignored.
// - Select held low after a read byte: address advances, next byte shifts out.
// - Select held low after a written byte: address advances, next byte stored.
// - A burst ends only when the host raises the select.
// - Address past the highest register wraps to zero during bursts.
// - Read data bits are launched on the serial clock falling edge.
// - Input data bits are sampled on the serial clock rising edge.
// - Port works only if the strap pins read binary 10 at reset.
// - All registers reachable directly; tables only through registers 121 to 131.
// - Host writes take effect at once, even while the switch is running.
module scrp_spi_client #(
   parameter int NUM_REGS = scrp_pkg::SCRP_NUM_REGS
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Serial pins from and to the host.
   input wire logic client_select_n,
   input wire logic serial_clock_pin,
   input wire logic serial_data_in_pin,
   output logic serial_data_out_pin,
   output logic serial_data_out_oe,
   // Strap pins.
   input wire logic [1:0] config_strap_pins,
   // Switch-core access to the live settings.
   input wire logic [7:0] core_rd_addr,
   output logic [7:0] core_rd_data,
   output logic ind_wr_pulse,
   output logic [7:0] ind_wr_addr,
   // Status.
   output logic spi_enabled
);
   import scrp_pkg::*;

   localparam logic [7:0] TOP_ADDR = 8'(NUM_REGS - 1);

   initial begin
      if (NUM_REGS < 1 || NUM_REGS > 256) begin
         $error("scrp_spi_client: NUM_REGS must be 1 to 256");
      end
   end

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic sclk_prev_q;
   logic [1:0] strap_s1_q;
   logic [1:0] strap_s2_q;
   logic [1:0] strap_cnt_q;
   logic spi_en_q;
   scrp_state_t state_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] rx_q;
   logic is_read_q;
   logic [7:0] addr_q;
   logic load_p_q;
   logic load_q;
   logic [7:0] tx_q;
   logic sdo_q;
   logic ind_q;
   logic [7:0] ind_addr_q;
   logic [7:0] rd_data;
   logic sel;
   logic sclk_s;
   logic mosi_s;
   logic rise;
   logic fall;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [7:0] addr_next;
   logic wr_en;

   // Two-stage synchronisers; the host clock is slow enough to be oversampled.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_q <= 3'h1;
         pin_s2_q <= 3'h1;
         sclk_prev_q <= 1'b0;
      end else begin
         pin_s1_q <= {serial_data_in_pin, serial_clock_pin, client_select_n};
         pin_s2_q <= pin_s1_q;
         sclk_prev_q <= pin_s2_q[1];
      end
   end

   assign sel = ~pin_s2_q[0] & spi_en_q;
   assign sclk_s = pin_s2_q[1];
   assign mosi_s = pin_s2_q[2];
   assign rise = sclk_s & ~sclk_prev_q;
   assign fall = ~sclk_s & sclk_prev_q;
   assign byte_done = sel && rise && (bit_cnt_q == SCRP_LAST_BIT);
   assign rx_byte = {rx_q[6:0], mosi_s};

   // strap latch: pins are synchronised, then caught once after release.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
         strap_cnt_q <= 2'h0;
         spi_en_q <= 1'b0;
      end else begin
         strap_s1_q <= config_strap_pins;
         strap_s2_q <= strap_s1_q;
         if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         if (strap_cnt_q == SCRP_STRAP_SETTLE) begin
            spi_en_q <= (strap_s2_q == SCRP_STRAP_SPI);
         end
      end
   end

   // rising-edge sampling into the shift register and bit counter.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_q <= 3'h0;
         rx_q <= 8'h00;
      end else if (!sel) begin
         bit_cnt_q <= 3'h0;
      end else if (rise) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         rx_q <= rx_byte;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= SCRP_ST_IDLE;
         is_read_q <= 1'b0;
      end else if (!sel) begin
         state_q <= SCRP_ST_IDLE;
      end else begin
         case (state_q)
            SCRP_ST_IDLE: begin
               state_q <= SCRP_ST_CMD;
            end
            SCRP_ST_CMD: begin
               if (byte_done) begin
                  is_read_q <= (rx_byte == SCRP_OP_READ);
                  if (rx_byte == SCRP_OP_READ || rx_byte == SCRP_OP_WRITE) begin
                     state_q <= SCRP_ST_ADDR;
                  end else begin
                     state_q <= SCRP_ST_SKIP;
                  end
               end
            end
            SCRP_ST_ADDR: begin
               if (byte_done) begin
                  state_q <= SCRP_ST_DATA;
               end
            end
            SCRP_ST_DATA: begin
               state_q <= SCRP_ST_DATA;
            end
            default: begin
               state_q <= SCRP_ST_SKIP;
            end
         endcase
      end
   end

   // wrap past the highest register; stray high addresses wrap as well.
   assign addr_next = (addr_q >= TOP_ADDR) ? 8'h00 : addr_q + 8'h01;

   // address counter advances after every data byte of a burst.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         addr_q <= 8'h00;
      end else if (byte_done && state_q == SCRP_ST_ADDR) begin
         addr_q <= rx_byte;
      end else if (byte_done && state_q == SCRP_ST_DATA) begin
         addr_q <= addr_next;
      end
   end

   // write goes straight into the live register file.
   assign wr_en = byte_done && state_q == SCRP_ST_DATA && !is_read_q;

   // pulse to the table engine when a window register is written.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ind_q <= 1'b0;
         ind_addr_q <= 8'h00;
      end else begin
         ind_q <= wr_en && addr_q >= SCRP_IND_FIRST && addr_q <= SCRP_IND_LAST;
         if (wr_en) begin
            ind_addr_q <= addr_q;
         end
      end
   end

   scrp_regfile #(
      .DEPTH(NUM_REGS),
      .AW(8)
   ) u_regs (
      .clk(mclk),
      .rstn(rstn),
      .wr_en(wr_en),
      .wr_addr(addr_q),
      .wr_data(rx_byte),
      .rd_addr(addr_q),
      .rd_data(rd_data),
      .core_addr(core_rd_addr),
      .core_data(core_rd_data)
   );

   // The read port lags the address by one cycle, well inside half a host clock.
   // One stage lets the new address land, the second waits for the registered read.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         load_p_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         load_p_q <= byte_done && is_read_q && state_q != SCRP_ST_CMD;
         load_q <= load_p_q;
      end
   end

   // falling-edge launch; next byte loaded after each read byte.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_q <= 8'h00;
         sdo_q <= SCRP_SDO_IDLE;
      end else if (!sel) begin
         sdo_q <= SCRP_SDO_IDLE;
      end else if (load_q) begin
         tx_q <= rd_data;
      end else if (fall && state_q == SCRP_ST_DATA && is_read_q) begin
         sdo_q <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   assign serial_data_out_pin = sdo_q;
   assign serial_data_out_oe = sel;
   assign ind_wr_pulse = ind_q;
   assign ind_wr_addr = ind_addr_q;
   assign spi_enabled = spi_en_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_cmd_byte(logic [7:0] op);
      byte_done && state_q == SCRP_ST_CMD && rx_byte == op;
   endsequence

   sequence s_data_byte;
      byte_done && state_q == SCRP_ST_DATA;
   endsequence

   a_cmd_read_decode: assert property (
      s_cmd_byte(SCRP_OP_READ) |=> state_q == SCRP_ST_ADDR && is_read_q
   ) else $error("read opcode not decoded");

   a_cmd_bad_skip: assert property (
      byte_done && state_q == SCRP_ST_CMD && rx_byte != SCRP_OP_READ
      && rx_byte != SCRP_OP_WRITE |=> state_q == SCRP_ST_SKIP
   ) else $error("unknown opcode accepted");

   a_read_advance: assert property (
      s_data_byte and is_read_q |=> addr_q == $past(addr_next) ##1 load_q
   ) else $error("read burst did not advance and reload");

   a_write_commit: assert property (
      s_data_byte and !is_read_q |-> wr_en ##1 addr_q == $past(addr_next)
   ) else $error("write byte not stored or address not advanced");

   a_burst_end: assert property (
      !sel |-> !serial_data_out_oe ##1 (state_q == SCRP_ST_IDLE && sdo_q == SCRP_SDO_IDLE)
   ) else $error("transfer kept open after select rose");

   a_addr_wrap: assert property (
      s_data_byte and addr_q == TOP_ADDR |=> addr_q == 8'h00
   ) else $error("address did not wrap to zero");

   a_launch_fall: assert property (
      sel && $changed(sdo_q) |-> $past(fall)
   ) else $error("output bit changed off a falling edge");

   a_sample_rise: assert property (
      sel && $past(sel) && $changed(bit_cnt_q) |-> $past(rise)
   ) else $error("input bit sampled off a rising edge");

   a_strap_gate: assert property (
      !spi_en_q |-> state_q == SCRP_ST_IDLE && !wr_en
   ) else $error("port active without the strap");

   a_ind_pulse: assert property (
      wr_en && addr_q == SCRP_IND_FIRST |=> ind_wr_pulse && ind_wr_addr == SCRP_IND_FIRST
   ) else $error("window write not flagged");
endmodule : scrp_spi_client

// ### scrp_host_model.sv
`timescale 1ns/100ps
// Host side of the serial link; the clock rests low outside frames.
module scrp_host_model (
   // Timing reference.
   input wire logic mclk,
   // Serial pins.
   output logic client_select_n,
   output logic serial_clock_pin,
   output logic serial_data_in_pin,
   input wire logic serial_data_out_pin
);
   // Pins start idle so the port sees no stray frame.
   initial begin
      client_select_n = 1'b1;
      serial_clock_pin = 1'b0;
      serial_data_in_pin = 1'b0;
   end

   task automatic half();
      repeat (4) @(negedge mclk);
   endtask : half

   task automatic sel(input logic lvl);
      client_select_n = lvl;
      if (lvl) serial_data_in_pin = ~serial_data_in_pin; // A released line must not look held.
      half();
   endtask : sel

   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_data_in_pin = tx[i];
         half();
         rx[i] = serial_data_out_pin; // Sampled just before the rise.
         serial_clock_pin = 1'b1;
         half();
         serial_clock_pin = 1'b0;
      end
   endtask : xbyte
endmodule : scrp_host_model

// ### test_spi_client_register_port.sv
`timescale 1ns/100ps
module test_spi_client_register_port;
   import scrp_pkg::*;
   logic mclk, rstn, sel_n, sck, sdi, sdo, oe, ind_pulse, en_out, en;
   logic [1:0] strap;
   logic [7:0] core_addr, core_data, ind_addr, ind_seen, ind_last;
   logic [7:0] mem [256];
   logic [7:0] wd [16];
   logic [31:0] seed = 32'h0000_35ba;
   logic [31:0] r;
   int fails = 0;
   int compares = 0;
   int ind_cnt = 0;
   int ind_exp = 0;

   scrp_spi_client scrp_spi_client_inst (.mclk(mclk), .rstn(rstn), .client_select_n(sel_n),
      .serial_clock_pin(sck), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo),
      .serial_data_out_oe(oe), .config_strap_pins(strap), .core_rd_addr(core_addr),
      .core_rd_data(core_data), .ind_wr_pulse(ind_pulse), .ind_wr_addr(ind_addr),
      .spi_enabled(en_out));
   scrp_host_model scrp_host_model_inst (.mclk(mclk), .client_select_n(sel_n),
      .serial_clock_pin(sck), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));

   // System clock, 40 ns period.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Pulses last one cycle, so they are counted mid-cycle, where they are settled.
   always @(negedge mclk) begin
      if (ind_pulse === 1'b1) begin
         ind_cnt++;
         ind_seen = ind_addr;
      end
   end

   // Xorshift source, fixed seed for repeatable runs.
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Next burst address, wrapping after the top register.
   function automatic logic [7:0] nxt(input logic [7:0] a);
      return (a >= 8'(SCRP_NUM_REGS - 1)) ? 8'h00 : a + 8'h01;
   endfunction : nxt

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic fill();
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         wd[i] = r[7:0];
      end
   endtask : fill

   // Strap is set while reset is low, so it is stable before release.
   task automatic do_reset(input logic [1:0] s);
      strap = s;
      rstn = 1'b0;
      repeat (3) @(negedge mclk);
      rstn = 1'b1;
      repeat (10) @(negedge mclk);
      en = (s === SCRP_STRAP_SPI);
      for (int i = 0; i < 256; i++) mem[i] = SCRP_REG_RESET;
      check("enabled", {7'h0, en_out}, {7'h0, en});
   endtask : do_reset

   task automatic xfer(input logic [7:0] op, input logic [7:0] a, input int n);
      logic [7:0] rx;
      logic [7:0] ad;
      ad = a;
      scrp_host_model_inst.sel(1'b0);
      check("oe", {7'h0, oe}, {7'h0, en});
      scrp_host_model_inst.xbyte(op, rx);
      scrp_host_model_inst.xbyte(a, rx);
      for (int i = 0; i < n; i++) begin
         scrp_host_model_inst.xbyte(wd[i], rx);
         check("sdo", rx, (en && op === SCRP_OP_READ) ? mem[ad] : 8'h00);
         if (en && op === SCRP_OP_WRITE && ad < 8'(SCRP_NUM_REGS)) begin
            mem[ad] = wd[i];
            if (ad >= SCRP_IND_FIRST && ad <= SCRP_IND_LAST) begin
               ind_exp++;
               ind_last = ad;
            end
         end
         ad = nxt(ad);
      end
      scrp_host_model_inst.sel(1'b1);
      check("ind count", 8'(ind_cnt), 8'(ind_exp));
      if (ind_exp > 0) check("ind addr", ind_seen, ind_last);
   endtask : xfer

   task automatic core_sweep();
      for (int i = 0; i < SCRP_NUM_REGS; i++) begin
         core_addr = 8'(i);
         @(negedge mclk);
         check("core", core_data, mem[i]);
      end
   endtask : core_sweep

   // Hangs are cut short here and end as a failure.
   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      stop_test();
   end

   initial begin
      rstn = 1'b0;
      strap = SCRP_STRAP_SPI;
      core_addr = 8'h00;
      en = 1'b0;
      ind_seen = 8'h00;
      ind_last = 8'h00;
      do_reset(SCRP_STRAP_SPI);
      fill();
      xfer(SCRP_OP_WRITE, 8'hc3, 5);
      xfer(SCRP_OP_READ, 8'hc3, 6);
      $display("test wrap done");
      fill();
      xfer(SCRP_OP_WRITE, 8'h78, 13);
      xfer(SCRP_OP_READ, 8'h78, 13);
      $display("test indirect done");
      fill();
      xfer(8'h01, 8'h10, 2);
      xfer(8'hff, 8'h10, 2);
      xfer(SCRP_OP_WRITE, 8'hc8, 2);
      xfer(SCRP_OP_READ, 8'hc6, 4);
      $display("test refuse done");
      repeat (12) begin
         fill();
         r = rnd();
         xfer(r[0] ? SCRP_OP_READ : SCRP_OP_WRITE, r[15:8], int'(r[3:2]) + 1);
      end
      core_sweep();
      $display("test random done");
      do_reset(2'h1);
      fill();
      xfer(SCRP_OP_WRITE, 8'h05, 2);
      xfer(SCRP_OP_READ, 8'h05, 2);
      do_reset(SCRP_STRAP_SPI);
      xfer(SCRP_OP_READ, 8'h05, 2);
      core_sweep();
      $display("test strap done");
      stop_test();
   end
endmodule : test_spi_client_register_port
